/* File: logic/tcc_channel0.sv */
// Purpose: Channel 0 of a 16-bit timer/event counter with compare/capture
// Assumes: count_tick_i is a one-cycle enable from a prescaler on core_clk_i
// Notes: Compare register loads are taken only while the counter is stopped
// How it works
// - Compare zero in free-run or edge-clear: interrupt on 0 to 1 after a wrap.
// - Interrupt also on match, each valid trigger edge, and one-shot clear.
// - Shared pin is trigger input or timer output, never both together.
// - A read meeting a capture may misread; the stored capture stays right.
// - Stop meeting a capture still captures the counter value.
// - Counter runs whenever the mode bits are not both zero, else stops.
module tcc_channel0 (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic srst_i,
  // Mode and options
  input wire logic op_mode_bit_low_i,
  input wire logic op_mode_bit_high_i,
  input wire logic count_tick_i,
  input wire logic capture_mode_i,
  input wire logic pin_out_sel_i,
  input wire logic one_shot_trig_i,
  // Edge selection
  input wire logic clr_rise_en_i,
  input wire logic clr_fall_en_i,
  input wire logic trig_rise_en_i,
  input wire logic trig_fall_en_i,
  // Compare register load
  input wire logic cmp_write_i,
  input wire logic [15:0] cmp_wdata_i,
  // Pins
  input wire logic clear_edge_input_i,
  input wire logic shared_port_pin_i,
  output logic shared_port_pin_o,
  output logic shared_port_pin_oe_n_o,
  // State and event
  output logic [15:0] timer_count_value_o,
  output logic [15:0] compare_capture_reg0_o,
  output logic channel0_irq_o
);
  logic [1:0] mode;
  logic running;
  logic clr_edge;
  logic trig_raw;
  logic trig_edge;
  logic wrapped;
  logic at_cmp;
  logic match_ev;
  logic clr_any;
  logic cap_take;
  logic wr_take;
  logic next_irq;
  logic tout;

  // Edge detectors for the clear pin and the shared pin
  tcc_edge_det u_clr_edge (
    .core_clk_i(core_clk_i),
    .srst_i(srst_i),
    .pin_i(clear_edge_input_i),
    .rise_en_i(clr_rise_en_i),
    .fall_en_i(clr_fall_en_i),
    .edge_o(clr_edge)
  );

  tcc_edge_det u_trig_edge (
    .core_clk_i(core_clk_i),
    .srst_i(srst_i),
    .pin_i(shared_port_pin_i),
    .rise_en_i(trig_rise_en_i),
    .fall_en_i(trig_fall_en_i),
    .edge_o(trig_raw)
  );

  // Mode decode and pin function split
  assign mode = {op_mode_bit_high_i, op_mode_bit_low_i};
  assign running = (mode != tcc_pkg::MODE_STOP);
  assign trig_edge = trig_raw & ~pin_out_sel_i;
  assign shared_port_pin_oe_n_o = ~pin_out_sel_i;
  assign shared_port_pin_o = tout;

  // Match: a zero compare only counts once the counter has wrapped
  assign at_cmp = (timer_count_value_o == compare_capture_reg0_o);
  assign match_ev = running && count_tick_i && at_cmp && !capture_mode_i &&
                    ((compare_capture_reg0_o != tcc_pkg::CMP_RST) || wrapped);
  assign clr_any = running && (one_shot_trig_i ||
                   (clr_edge && (mode == tcc_pkg::MODE_EDGE_CLR)) ||
                   (match_ev && (mode == tcc_pkg::MODE_MATCH_CLR)));

  // Capture wins over a load; loads only while stopped
  assign cap_take = capture_mode_i && trig_edge;
  assign wr_take = cmp_write_i && !running && !cap_take;
  assign next_irq = match_ev || trig_edge || (running && one_shot_trig_i);

  // Counter
  always_ff @(posedge core_clk_i) begin
    if (srst_i || !running) begin
      timer_count_value_o <= tcc_pkg::CNT_ZERO;
    end else if (clr_any) begin
      timer_count_value_o <= tcc_pkg::CNT_ZERO;
    end else if (count_tick_i) begin
      timer_count_value_o <= timer_count_value_o + tcc_pkg::CNT_ONE;
    end
  end

  // Wrap memory for a zero compare value
  always_ff @(posedge core_clk_i) begin
    if (srst_i || !running || clr_any) begin
      wrapped <= 1'h0;
    end else if (count_tick_i && (timer_count_value_o == tcc_pkg::CNT_MAX)) begin
      wrapped <= 1'h1;
    end
  end

  // Compare/capture register, captured even when a stop coincides
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      compare_capture_reg0_o <= tcc_pkg::CMP_RST;
    end else if (cap_take) begin
      compare_capture_reg0_o <= timer_count_value_o;
    end else if (wr_take) begin
      compare_capture_reg0_o <= cmp_wdata_i;
    end
  end

  // Interrupt pulse
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      channel0_irq_o <= 1'h0;
    end else begin
      channel0_irq_o <= next_irq;
    end
  end

  // Timer output toggles on each match
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      tout <= tcc_pkg::TOUT_RST;
    end else if (match_ev) begin
      tout <= ~tout;
    end
  end

  // Checks
  sequence s_zero_step;
    running && count_tick_i && !clr_any && !capture_mode_i && wrapped &&
      (timer_count_value_o == tcc_pkg::CNT_ZERO) &&
      (compare_capture_reg0_o == tcc_pkg::CMP_RST);
  endsequence

  sequence s_irq_after_one;
    (timer_count_value_o == tcc_pkg::CNT_ONE) && channel0_irq_o;
  endsequence

  property p_zero_wrap_irq;
    @(posedge core_clk_i) disable iff (srst_i)
      s_zero_step |=> s_irq_after_one;
  endproperty
  a_zero_wrap_irq: assert property (p_zero_wrap_irq)
    else $error("No interrupt on 0 to 1 step after wrap");

  property p_match_irq;
    @(posedge core_clk_i) disable iff (srst_i)
      (running && count_tick_i && at_cmp && !capture_mode_i &&
       (compare_capture_reg0_o != tcc_pkg::CMP_RST)) |=> channel0_irq_o;
  endproperty
  a_match_irq: assert property (p_match_irq)
    else $error("No interrupt after compare match");

  property p_pin_exclusive;
    @(posedge core_clk_i) disable iff (srst_i)
      pin_out_sel_i |-> (!shared_port_pin_oe_n_o && !trig_edge && !cap_take);
  endproperty
  a_pin_exclusive: assert property (p_pin_exclusive)
    else $error("Shared pin used as input and output together");

  property p_reg_stable;
    @(posedge core_clk_i) disable iff (srst_i)
      $changed(compare_capture_reg0_o) |-> $past(cap_take || wr_take);
  endproperty
  a_reg_stable: assert property (p_reg_stable)
    else $error("Compare/capture register changed without cause");

  property p_capture_on_stop;
    @(posedge core_clk_i) disable iff (srst_i)
      (cap_take && !running) |=> (compare_capture_reg0_o == $past(timer_count_value_o));
  endproperty
  a_capture_on_stop: assert property (p_capture_on_stop)
    else $error("Capture lost while counter stopped");

  property p_stop_holds;
    @(posedge core_clk_i) disable iff (srst_i)
      !running [*2] |-> (timer_count_value_o == tcc_pkg::CNT_ZERO);
  endproperty
  a_stop_holds: assert property (p_stop_holds)
    else $error("Counter not held at zero while stopped");

  property p_count_step;
    @(posedge core_clk_i) disable iff (srst_i)
      (running && count_tick_i && !clr_any) |=>
        (timer_count_value_o == 16'($past(timer_count_value_o) + tcc_pkg::CNT_ONE));
  endproperty
  a_count_step: assert property (p_count_step)
    else $error("Counter did not step on count tick");

  property p_capture;
    @(posedge core_clk_i) disable iff (srst_i)
      (capture_mode_i && trig_edge) |=> channel0_irq_o &&
        (compare_capture_reg0_o == $past(timer_count_value_o));
  endproperty
  a_capture: assert property (p_capture)
    else $error("Capture did not latch counter value");
endmodule

/* File: logic/tcc_edge_det.sv */
// Purpose: Synchronise a pin and flag its selected valid edges
// Assumes: Pin is asynchronous to core_clk_i
// Notes: Edge pulse lasts one cycle, two to three cycles after the pin moves;
// hold reset three cycles so the history holds the pin's idle level
module tcc_edge_det (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic srst_i,
  // Pin and edge selection
  input wire logic pin_i,
  input wire logic rise_en_i,
  input wire logic fall_en_i,
  // Result
  output logic edge_o
);
  logic sync_a;
  logic sync_b;
  logic prev;

  // Two-stage synchroniser, then one stage of history; it runs through reset so a
  // pin that idles high shows no false edge after release
  always_ff @(posedge core_clk_i) begin
    sync_a <= pin_i;
    sync_b <= sync_a;
    prev <= sync_b;
  end

  // Valid edge by selection, held off while reset is applied
  assign edge_o = !srst_i && ((sync_b & ~prev & rise_en_i) | (~sync_b & prev & fall_en_i));
endmodule

/* File: logic/tcc_pkg.sv */
// Purpose: Shared constants for timer channel 0 compare/capture logic
// Assumes: One 20 MHz core clock, prescaled count ticks arrive as enables
// Notes: Mode codes follow the two operating-mode bits {high, low}
package tcc_pkg;
  // Counter and register width
  localparam int CNT_W = 16;
  // Counter limits
  localparam logic [15:0] CNT_ZERO = 16'h0000;
  localparam logic [15:0] CNT_ONE = 16'h0001;
  localparam logic [15:0] CNT_MAX = 16'hFFFF;
  // Reset values
  localparam logic [15:0] CMP_RST = 16'h0000;
  localparam logic TOUT_RST = 1'h0;
  // Operating modes, {op_mode_bit_high, op_mode_bit_low}
  localparam logic [1:0] MODE_STOP = 2'h0;
  localparam logic [1:0] MODE_EDGE_CLR = 2'h1;
  localparam logic [1:0] MODE_FREE = 2'h2;
  localparam logic [1:0] MODE_MATCH_CLR = 2'h3;
endpackage

/* File: sim/tcc_channel0_tb.sv */
// Purpose: Self-checking bench for timer channel 0 with a cycle model
// Assumes: Ticks come from a seeded random stream or run every cycle
// Notes: Clear-pin edges drive one edge-clear pass; the model follows both pins
module tcc_channel0_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, srst, ml, mh, tick, cap, sel, os, tre, tfe, cre, cfe, wr, trig_lvl, clr_lvl;
  logic pin_lvl, pin_o, oe_n, irq, ew, ei, ep, run_t, all_t, trg_m, clr_m, run_m, hit, clr;
  logic [2:0] ms, mc;
  logic [15:0] wd, cnt, rg, ec, cmp_m;
  int bad_count, samples_checked, irq_n, ei_n, n, seed;
  logic [31:0] r;
  tcc_channel0 DUT (.core_clk_i(clk), .srst_i(srst), .op_mode_bit_low_i(ml),
    .op_mode_bit_high_i(mh), .count_tick_i(tick), .capture_mode_i(cap),
    .pin_out_sel_i(sel), .one_shot_trig_i(os), .clr_rise_en_i(cre), .clr_fall_en_i(cfe),
    .trig_rise_en_i(tre), .trig_fall_en_i(tfe), .cmp_write_i(wr), .cmp_wdata_i(wd),
    .clear_edge_input_i(clr_lvl), .shared_port_pin_i(pin_lvl), .shared_port_pin_o(pin_o),
    .shared_port_pin_oe_n_o(oe_n), .timer_count_value_o(cnt),
    .compare_capture_reg0_o(rg), .channel0_irq_o(irq));
  tcc_pin_partner u_pin (.trig_lvl_i(trig_lvl), .tout_i(pin_o), .oe_n_i(oe_n),
    .pin_level_o(pin_lvl));
  // Clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // Tick stream
  always @(posedge clk) begin
    r = $random(seed);
    tick <= run_t & (all_t | r[0]);
  end
  // Model view of the pins: an edge acts three clock edges after the pin moves
  always @(posedge clk) begin
    ms <= {ms[1:0], pin_lvl};
    mc <= {mc[1:0], clr_lvl};
  end
  assign trg_m = !sel & ((ms[1] & !ms[2] & tre) | (!ms[1] & ms[2] & tfe));
  assign clr_m = (mc[1] & !mc[2] & cre) | (!mc[1] & mc[2] & cfe);
  // Cycle model of counter, wrap memory, interrupt, timer output and register
  always @(posedge clk) begin
    run_m = ({mh, ml} != 2'h0);
    hit = run_m & tick & !cap & (ec == cmp_m) & ((cmp_m != 16'h0000) | ew);
    clr = run_m & (os | (clr_m & ({mh, ml} == 2'h1)) | (hit & ({mh, ml} == 2'h3)));
    if (srst) begin
      ec <= 16'h0000;
      ew <= 1'b0;
      ei <= 1'b0;
      ep <= 1'b0;
      cmp_m <= 16'h0000;
    end else begin
      ei <= hit | trg_m | (run_m & os);
      if (hit) ep <= ~ep;
      if (cap & trg_m) cmp_m <= ec;
      else if (wr & !run_m) cmp_m <= wd;
      if (!run_m | clr) ec <= 16'h0000;
      else if (tick) ec <= ec + 16'h0001;
      if (!run_m | clr) ew <= 1'b0;
      else if (tick & (ec == 16'hFFFF)) ew <= 1'b1;
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: %s", $time, m);
    end
  endtask
  // Compare design with model where outputs have settled
  always @(negedge clk) begin
    if (!srst) begin
      chk(16'(oe_n), 16'(!sel), "pin direction");
      chk(cnt, ec, "count");
      chk(16'(irq), 16'(ei), "irq");
      chk(rg, cmp_m, "compare reg");
      chk(16'(pin_o), 16'(ep), "timer output");
      if (irq === 1'b1) irq_n++;
      if (ei === 1'b1) ei_n++;
    end
  end
  task automatic go(input logic [1:0] m);
    @(posedge clk);
    {mh, ml} <= m;
  endtask
  task automatic ld(input logic [15:0] v);
    @(posedge clk);
    wr <= 1'b1;
    wd <= v;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic test_done;
    $display("checks %0d, mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // Watchdog
  initial begin
    #4000000;
    bad_count++;
    test_done;
  end
  // Main sequence
  initial begin
    seed = 85421;
    {srst, ml, mh, cap, sel, os, tre, tfe, cre, cfe, wr} = 11'h400;
    {trig_lvl, clr_lvl, run_t, all_t} = 4'h0;
    wd = 16'h0000;
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    ld(16'h0005);
    go(2'h2);
    ld(16'h0009); // Dropped by the design: the timer is running
    run_t <= 1'b1;
    repeat (200) @(posedge clk);
    $display("test free-run match done");
    go(2'h0);
    ld(16'h0025);
    go(2'h3);
    repeat (300) @(posedge clk);
    $display("test clear-on-match done");
    go(2'h0);
    ld(16'h0000);
    all_t <= 1'b1;
    go(2'h2);
    repeat (65545) @(posedge clk);
    $display("test zero compare after wrap done");
    go(2'h0);
    ld(16'h0010);
    cre <= 1'b1;
    cfe <= 1'b1;
    go(2'h1);
    repeat (3) begin
      repeat (30) @(posedge clk);
      clr_lvl <= ~clr_lvl;
    end
    repeat (30) @(posedge clk);
    $display("test edge clear done");
    go(2'h0);
    cap <= 1'b1;
    tre <= 1'b1;
    tfe <= 1'b1;
    go(2'h2);
    repeat (20) @(posedge clk);
    trig_lvl <= 1'b1;
    n = 0;
    while (irq !== 1'b1 && n < 10) begin
      @(negedge clk);
      n++;
    end
    chk(rg, ec - 16'h0001, "captured value");
    chk(16'(n < 10), 16'h0001, "capture irq");
    repeat (8) @(posedge clk);
    trig_lvl <= 1'b0;
    repeat (10) @(posedge clk);
    $display("test capture done");
    go(2'h0);
    cap <= 1'b0;
    sel <= 1'b1;
    ld(16'h0003);
    go(2'h3);
    irq_n = 0;
    ei_n = 0;
    trig_lvl <= 1'b1;
    repeat (10) @(posedge clk);
    trig_lvl <= 1'b0;
    repeat (10) @(posedge clk);
    chk(16'(irq_n), 16'(ei_n), "trigger while output");
    chk(16'(irq_n > 0), 16'h0001, "match irq while output");
    $display("test pin as output done");
    go(2'h0);
    ld(16'h8000);
    go(2'h2);
    repeat (3) @(posedge clk);
    irq_n = 0;
    os <= 1'b1;
    @(posedge clk);
    os <= 1'b0;
    repeat (5) @(posedge clk);
    chk(16'(irq_n), 16'h0001, "one-shot irq");
    $display("test one-shot done");
    test_done;
  end
endmodule

/* File: sim/tcc_pin_partner.sv */
// Purpose: Far side of the shared pin, a trigger source and an output load
// Assumes: Design drives the pin while its output enable is low
// Notes: Trigger level comes from the bench, held long enough for capture
module tcc_pin_partner (
  // Bench side
  input wire logic trig_lvl_i,
  // Design side
  input wire logic tout_i,
  input wire logic oe_n_i,
  output logic pin_level_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // Wire level: design output when enabled, else the trigger source
  assign pin_level_o = oe_n_i ? trig_lvl_i : tout_i;
endmodule
